//--- core/ccl_pkg.sv
package ccl_pkg;

  // register map
  localparam int         AXI_AW     = 8;
  localparam logic [7:0] ROOT_OFS   = 8'h00;
  localparam logic [7:0] CTRL_OFS   = 8'h04;
  localparam logic [7:0] STAT_OFS   = 8'h08;
  localparam logic [7:0] MASK_OFS   = 8'h0c;
  localparam logic [7:0] STATE_OFS  = 8'h10;

  // root register fields
  localparam int ROOT_FLUSH_BIT = 5;
  localparam int ROOT_BASE_LSB  = 12;

  // control register fields
  localparam int CTRL_WP_BIT   = 0;
  localparam int CTRL_PAR_BIT  = 1;
  localparam int CTRL_SOLO_BIT = 2;
  localparam int CTRL_W        = 3;

  // event bits, shared by status and mask
  localparam int NUM_EV   = 5;
  localparam int EV_FLUSH = 0;
  localparam int EV_REFUSE = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_SNOOP = 3;
  localparam int EV_FWD   = 4;

  // reset values
  localparam logic [19:0]       ROOT_RST = 20'h00000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [NUM_EV-1:0] MASK_RST = 5'h00;

  // translation entry attribute bits, low bits of a table entry
  localparam int PTE_P  = 0;
  localparam int PTE_W  = 1;
  localparam int PTE_U  = 2;
  localparam int PTE_WT = 3;
  localparam int PTE_NC = 4;
  localparam int PTE_A  = 5;
  localparam int PTE_D  = 6;
  localparam int PTE_AW = 7;

  localparam int PFLD_STAGES = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOK = 2'b01,
    ST_WALK = 2'b10,
    ST_BUS  = 2'b11
  } ccl_state_type;

  typedef enum logic [1:0] {
    CS_I = 2'b00,
    CS_S = 2'b01,
    CS_E = 2'b10,
    CS_M = 2'b11
  } ccl_line_type;

endpackage

//--- core/ccl_core.sv
// Functional notes
// R1 - table walks fetch entries from external memory only, never from data cache
// R2 - line write-back ignores the page protection and status flags
// R3 - entries with present or accessed flag clear are never installed
// R4 - paging unit write cycles are snooped; matching data line invalidated
// R5 - entry raising load/store or fetch fault trap is invalidated by hardware
// R6 - no-cache page access that hits is served by cache, no bus cycle; shared-line store hits and S/E-hit float loads still go to the bus
// R7 - store-through page store hitting exclusive/modified line updates cache only
// R8 - supervisor write guard is not held in translation entries
// R9 - pipelined float loads never allocate into the data cache
// R10 - pipelined float load hitting modified line forwards cached data down pipe
// R11 - software sets flush bit in root register after page table changes
// R12 - software flushes data cache before invalidation for write-back tables
// R13 - software invalidates instruction cache after modifying code
// R14 - trap handler may set dirty flag without data cache flush
// R15 - software flushes caches before enabling standalone and parallel unit
// R16 - root write with flush bit clears instruction and translation caches
// R17 - that clearing completes before any later fetch or access uses them
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module ccl_core
  import ccl_pkg::*;
#(
  parameter int TLB_IW = 3,
  parameter int DC_IW  = 4,
  parameter int IC_IW  = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              irq,
  input  wire logic              core_req_valid,
  output wire logic              core_req_ready,
  input  wire logic [31:0]       core_req_addr,
  input  wire logic              core_req_write,
  input  wire logic [31:0]       core_req_wdata,
  input  wire logic              core_req_super,
  input  wire logic              core_req_pfld,
  output wire logic              core_rsp_valid,
  output wire logic              core_rsp_fault,
  output wire logic [31:0]       core_rsp_data,
  input  wire logic              fetch_fault_valid,
  input  wire logic [31:0]       fetch_fault_vaddr,
  output wire logic              walk_req_valid,
  output wire logic [19:0]       walk_req_vpn,
  output wire logic [19:0]       walk_req_root,
  input  wire logic              walk_rsp_valid,
  input  wire logic [31:0]       walk_rsp_pte,
  input  wire logic              walk_wr_valid,
  input  wire logic [31:0]       walk_wr_addr,
  output wire logic              bus_req_valid,
  output wire logic              bus_req_write,
  output wire logic [31:0]       bus_req_addr,
  output wire logic [31:0]       bus_req_wdata,
  input  wire logic              bus_ack,
  input  wire logic              bus_shared,
  input  wire logic [31:0]       bus_rdata,
  output wire logic              pfld_out_valid,
  output wire logic [31:0]       pfld_out_data,
  input  wire logic              ic_fill_valid,
  input  wire logic [31:0]       ic_fill_addr,
  input  wire logic [31:0]       ic_lookup_addr,
  output wire logic              ic_hit
);

  localparam int TN = 1 << TLB_IW;
  localparam int DN = 1 << DC_IW;
  localparam int IN = 1 << IC_IW;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [DC_IW-1:0] dc_idx(input logic [31:0] a);
    return a[DC_IW+1:2];
  endfunction

  function automatic logic [TLB_IW-1:0] tlb_idx(input logic [31:0] a);
    return a[TLB_IW+11:12];
  endfunction

  // ---------------- register bus ----------------
  logic              aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [19:0]       root_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [NUM_EV-1:0] stat_q, mask_q, ev_q;
  logic              flush_pend_q;

  wire        do_wr   = aw_hold_q & w_hold_q & ~bvalid_q;
  wire        do_rd   = s_axi_arvalid & ~rvalid_q;
  wire        wr_root = do_wr && awaddr_q == ROOT_OFS;
  wire        wr_ctrl = do_wr && awaddr_q == CTRL_OFS;
  wire        wr_stat = do_wr && awaddr_q == STAT_OFS;
  wire        wr_mask = do_wr && awaddr_q == MASK_OFS;
  wire        wr_hit  = wr_root | wr_ctrl | wr_stat | wr_mask;
  wire [31:0] root_rd = {root_q, 12'h000};
  wire [31:0] root_wr = merge(root_rd, wdata_q, wstrb_q);
  wire [31:0] ctrl_wr = merge({29'h0, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] mask_wr = merge({27'h0, mask_q}, wdata_q, wstrb_q);
  wire [31:0] stat_clr = merge(32'h0, wdata_q, wstrb_q);
  wire [NUM_EV-1:0] stat_d = (stat_q & ~(wr_stat ? stat_clr[NUM_EV-1:0]
                                         : '0)) | ev_q;

  ccl_state_type st_q;
  wire rd_known = s_axi_araddr == ROOT_OFS || s_axi_araddr == CTRL_OFS ||
                  s_axi_araddr == STAT_OFS || s_axi_araddr == MASK_OFS ||
                  s_axi_araddr == STATE_OFS;
  wire [31:0] rd_mux =
    s_axi_araddr == ROOT_OFS ? root_rd :
    s_axi_araddr == CTRL_OFS ? {29'h0, ctrl_q} :
    s_axi_araddr == STAT_OFS ? {27'h0, stat_q} :
    s_axi_araddr == MASK_OFS ? {27'h0, mask_q} :
    s_axi_araddr == STATE_OFS ? {29'h0, flush_pend_q, st_q} : 32'h0;

  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready  = ~w_hold_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = |(stat_q & mask_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      bvalid_q     <= 1'b0;
      bresp_q      <= RESP_OKAY;
      rvalid_q     <= 1'b0;
      rdata_q      <= 32'h0;
      rresp_q      <= RESP_OKAY;
      root_q       <= ROOT_RST;
      ctrl_q       <= CTRL_RST;
      mask_q       <= MASK_RST;
      stat_q       <= '0;
      flush_pend_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_rd) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_known ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      if (wr_root) begin
        root_q <= root_wr[31:ROOT_BASE_LSB];
      end
      if (wr_ctrl) begin
        ctrl_q <= ctrl_wr[CTRL_W-1:0];
      end
      if (wr_mask) begin
        mask_q <= mask_wr[NUM_EV-1:0];
      end
      stat_q       <= stat_d; // set beats a same-cycle clear
      flush_pend_q <= wr_root && wstrb_q[0] && wdata_q[ROOT_FLUSH_BIT]; // R16
    end
  end

  // ---------------- access path ----------------
  logic [19:0]       tlb_vpn_q  [TN];
  logic [19:0]       tlb_pfn_q  [TN];
  logic [PTE_AW-1:0] tlb_attr_q [TN]; // R8
  logic [TN-1:0]     tlb_v_q;
  logic [29:0]       dc_tag_q   [DN];
  logic [31:0]       dc_dat_q   [DN];
  ccl_line_type      dc_st_q    [DN];
  logic [29:0]       ic_tag_q   [IN];
  logic [IN-1:0]     ic_v_q;

  logic [31:0] req_addr_q, req_wdata_q, rsp_data_q;
  logic        req_wr_q, req_super_q, req_pfld_q;
  logic        rsp_v_q, rsp_fault_q, walk_v_q, wb_q, alloc_q;
  logic        bus_v_q, bus_wr_q;
  logic [31:0] bus_addr_q, bus_wdata_q;
  logic        pf0_v_q, pf1_v_q, pf2_v_q;
  logic [31:0] pf0_d_q, pf1_d_q, pf2_d_q;

  wire [19:0]       vpn      = req_addr_q[31:12];
  wire [TLB_IW-1:0] ti       = tlb_idx(req_addr_q);
  wire              tlb_hit  = tlb_v_q[ti] && tlb_vpn_q[ti] == vpn;
  wire [PTE_AW-1:0] attr     = tlb_attr_q[ti];
  wire              wp_guard = ctrl_q[CTRL_WP_BIT];
  // guard read live from control, so changing it needs no invalidation
  wire prot_fault = (!attr[PTE_U] && !req_super_q) ||
                    (req_wr_q && !attr[PTE_W] && (!req_super_q || wp_guard)) ||
                    (req_wr_q && !attr[PTE_D]); // R8
  wire [31:0]       pa      = {tlb_pfn_q[ti], req_addr_q[11:0]};
  wire [DC_IW-1:0]  di      = dc_idx(pa);
  wire              dc_hit  = dc_st_q[di] != CS_I && dc_tag_q[di] == pa[31:2];
  wire              dc_excl = dc_hit && (dc_st_q[di] == CS_E ||
                                         dc_st_q[di] == CS_M);
  wire              dc_mod  = dc_hit && dc_st_q[di] == CS_M;
  wire              victim_m = !dc_hit && dc_st_q[di] == CS_M;
  wire              cacheable = !attr[PTE_NC] && !req_pfld_q; // R9
  wire              pte_ok  = walk_rsp_pte[PTE_P] && walk_rsp_pte[PTE_A];
  wire [TLB_IW-1:0] ff_i    = tlb_idx(fetch_fault_vaddr);
  wire              ff_hit  = fetch_fault_valid &&
                              tlb_vpn_q[ff_i] == fetch_fault_vaddr[31:12];
  wire [DC_IW-1:0]  sn_i    = dc_idx(walk_wr_addr);
  wire              sn_hit  = walk_wr_valid && dc_st_q[sn_i] != CS_I &&
                              dc_tag_q[sn_i] == walk_wr_addr[31:2];
  wire [IC_IW-1:0]  ic_li   = ic_lookup_addr[IC_IW+1:2];
  wire [IC_IW-1:0]  ic_fi   = ic_fill_addr[IC_IW+1:2];

  assign core_req_ready = st_q == ST_IDLE && !flush_pend_q; // R17
  assign core_rsp_valid = rsp_v_q;
  assign core_rsp_fault = rsp_fault_q;
  assign core_rsp_data  = rsp_data_q;
  assign walk_req_valid = walk_v_q;
  assign walk_req_vpn   = vpn;
  assign walk_req_root  = root_q;
  assign bus_req_valid  = bus_v_q;
  assign bus_req_write  = bus_wr_q;
  assign bus_req_addr   = bus_addr_q;
  assign bus_req_wdata  = bus_wdata_q;
  assign pfld_out_valid = pf2_v_q;
  assign pfld_out_data  = pf2_d_q;
  assign ic_hit = ic_v_q[ic_li] && ic_tag_q[ic_li] == ic_lookup_addr[31:2] &&
                  !flush_pend_q; // R17

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q        <= ST_IDLE;
      req_addr_q  <= 32'h0;
      req_wdata_q <= 32'h0;
      req_wr_q    <= 1'b0;
      req_super_q <= 1'b0;
      req_pfld_q  <= 1'b0;
      rsp_v_q     <= 1'b0;
      rsp_fault_q <= 1'b0;
      rsp_data_q  <= 32'h0;
      walk_v_q    <= 1'b0;
      wb_q        <= 1'b0;
      alloc_q     <= 1'b0;
      bus_v_q     <= 1'b0;
      bus_wr_q    <= 1'b0;
      bus_addr_q  <= 32'h0;
      bus_wdata_q <= 32'h0;
      pf0_v_q     <= 1'b0;
      pf0_d_q     <= 32'h0;
      ev_q        <= '0;
      tlb_v_q     <= '0;
      ic_v_q      <= '0;
      for (int i = 0; i < TN; i++) begin
        tlb_vpn_q[i]  <= 20'h0;
        tlb_pfn_q[i]  <= 20'h0;
        tlb_attr_q[i] <= '0;
      end
      for (int i = 0; i < DN; i++) begin
        dc_tag_q[i] <= 30'h0;
        dc_dat_q[i] <= 32'h0;
        dc_st_q[i]  <= CS_I;
      end
      for (int i = 0; i < IN; i++) begin
        ic_tag_q[i] <= 30'h0;
      end
    end else begin
      rsp_v_q <= 1'b0;
      pf0_v_q <= 1'b0;
      ev_q    <= '0;
      case (st_q)
        ST_IDLE: begin
          if (core_req_valid && core_req_ready) begin
            req_addr_q  <= core_req_addr;
            req_wdata_q <= core_req_wdata;
            req_wr_q    <= core_req_write;
            req_super_q <= core_req_super;
            req_pfld_q  <= core_req_pfld;
            st_q        <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          rsp_fault_q <= 1'b0;
          if (!tlb_hit) begin
            walk_v_q <= 1'b1; // R1
            st_q     <= ST_WALK;
          end else if (prot_fault) begin
            tlb_v_q[ti]     <= 1'b0; // R5
            ev_q[EV_FAULT]  <= 1'b1;
            rsp_v_q         <= 1'b1;
            rsp_fault_q     <= 1'b1;
            st_q            <= ST_IDLE;
          end else if (req_pfld_q && dc_mod) begin
            pf0_v_q       <= 1'b1; // R10
            pf0_d_q       <= dc_dat_q[di];
            ev_q[EV_FWD]  <= 1'b1;
            rsp_v_q       <= 1'b1;
            st_q          <= ST_IDLE;
          end else if (dc_hit && !req_pfld_q && !req_wr_q) begin
            rsp_v_q    <= 1'b1; // R6
            rsp_data_q <= dc_dat_q[di];
            st_q       <= ST_IDLE;
          end else if (dc_excl && !req_pfld_q) begin
            dc_dat_q[di] <= req_wdata_q; // R7
            dc_st_q[di]  <= CS_M;
            rsp_v_q      <= 1'b1;
            st_q         <= ST_IDLE;
          end else if (victim_m && cacheable && !req_wr_q) begin
            // write-back takes the line as it is, no page flags consulted
            wb_q        <= 1'b1; // R2
            bus_v_q     <= 1'b1;
            bus_wr_q    <= 1'b1;
            bus_addr_q  <= {dc_tag_q[di], 2'b00};
            bus_wdata_q <= dc_dat_q[di];
            st_q        <= ST_BUS;
          end else begin
            // shared hit stores write through; misses go to the bus
            if (dc_hit && req_wr_q) begin
              dc_dat_q[di] <= req_wdata_q;
            end
            wb_q        <= 1'b0;
            alloc_q     <= cacheable && !req_wr_q; // R9
            bus_v_q     <= 1'b1;
            bus_wr_q    <= req_wr_q;
            bus_addr_q  <= pa;
            bus_wdata_q <= req_wdata_q;
            st_q        <= ST_BUS;
          end
        end
        ST_WALK: begin
          if (walk_rsp_valid) begin
            walk_v_q <= 1'b0;
            if (pte_ok) begin
              tlb_v_q[ti]    <= 1'b1; // R3
              tlb_vpn_q[ti]  <= vpn;
              tlb_pfn_q[ti]  <= walk_rsp_pte[31:12];
              tlb_attr_q[ti] <= walk_rsp_pte[PTE_AW-1:0];
              st_q           <= ST_LOOK;
            end else begin
              ev_q[EV_REFUSE] <= 1'b1; // R3
              rsp_v_q         <= 1'b1;
              rsp_fault_q     <= 1'b1;
              st_q            <= ST_IDLE;
            end
          end
        end
        ST_BUS: begin
          if (bus_ack) begin
            bus_v_q <= 1'b0;
            if (wb_q) begin
              dc_st_q[di] <= CS_I;
              wb_q        <= 1'b0;
              st_q        <= ST_LOOK;
            end else begin
              if (req_pfld_q) begin
                pf0_v_q <= 1'b1;
                pf0_d_q <= bus_rdata;
              end
              if (alloc_q) begin
                dc_tag_q[di] <= pa[31:2];
                dc_dat_q[di] <= bus_rdata;
                dc_st_q[di]  <= bus_shared ? CS_S : CS_E;
              end
              rsp_v_q    <= 1'b1;
              rsp_data_q <= bus_rdata;
              st_q       <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (ic_fill_valid) begin
        ic_v_q[ic_fi]   <= 1'b1;
        ic_tag_q[ic_fi] <= ic_fill_addr[31:2];
      end
      // invalidations last so they override any fill in the same edge
      if (ff_hit) begin
        tlb_v_q[ff_i]  <= 1'b0; // R5
        ev_q[EV_FAULT] <= 1'b1;
      end
      if (sn_hit) begin
        dc_st_q[sn_i]  <= CS_I; // R4
        ev_q[EV_SNOOP] <= 1'b1;
      end
      if (flush_pend_q) begin
        tlb_v_q        <= '0; // R16
        ic_v_q         <= '0;
        ev_q[EV_FLUSH] <= 1'b1;
      end
    end
  end

  // three-stage load pipe; memory and forwarded data share it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pf1_v_q <= 1'b0;
      pf2_v_q <= 1'b0;
      pf1_d_q <= 32'h0;
      pf2_d_q <= 32'h0;
    end else begin
      pf1_v_q <= pf0_v_q; // R10
      pf1_d_q <= pf0_d_q;
      pf2_v_q <= pf1_v_q;
      pf2_d_q <= pf1_d_q;
    end
  end

endmodule

//--- testbench/ccl_mem_model.sv
`timescale 1ns/1ps
module ccl_mem_model (
  input  logic        clk_sys,
  input  logic        rst,
  input  logic [6:0]  pte_attr,
  input  logic        walk_req_valid,
  input  logic [19:0] walk_req_vpn,
  output logic        walk_rsp_valid,
  output logic [31:0] walk_rsp_pte,
  input  logic        bus_req_valid,
  input  logic [31:0] bus_req_addr,
  output logic        bus_ack,
  output logic        bus_shared,
  output logic [31:0] bus_rdata
);
  logic [1:0] wd_q;
  logic [1:0] bd_q;
  // fills always exclusive; sharing is not exercised here
  assign bus_shared = 1'b0;
  // slow answers; idle data lines toggle so stale values never match
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wd_q <= 2'h0;
      bd_q <= 2'h0;
      walk_rsp_valid <= 1'b0;
      bus_ack <= 1'b0;
      walk_rsp_pte <= 32'h0;
      bus_rdata <= 32'h0;
    end else begin
      wd_q <= (walk_req_valid && !walk_rsp_valid) ? wd_q + 2'h1 : 2'h0;
      bd_q <= (bus_req_valid && !bus_ack) ? bd_q + 2'h1 : 2'h0;
      walk_rsp_valid <= wd_q == 2'h2;
      bus_ack <= bd_q == 2'h2;
      walk_rsp_pte <= (wd_q == 2'h2) ? {walk_req_vpn, 5'h0, pte_attr}
                                      : ~walk_rsp_pte;
      bus_rdata <= (bd_q == 2'h2) ? {bus_req_addr[15:0], 16'hc3c3}
                                   : ~bus_rdata;
    end
  end
endmodule

//--- testbench/ccl_core_chk.sv
`timescale 1ns/1ps
module ccl_core_chk
  import ccl_pkg::*;
(
  input logic              clk_sys,
  input logic              rst,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic [AXI_AW-1:0] s_axi_araddr,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready,
  input logic [31:0]       s_axi_rdata,
  input logic [1:0]        s_axi_rresp,
  input logic              s_axi_bvalid,
  input logic              s_axi_bready,
  input logic [1:0]        s_axi_bresp,
  input logic              core_rsp_valid,
  input logic              core_rsp_fault,
  input logic              walk_req_valid,
  input logic              walk_rsp_valid,
  input logic [31:0]       walk_rsp_pte,
  input logic              bus_req_valid,
  input logic [31:0]       bus_req_addr,
  input logic              bus_ack
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > STATE_OFS |=>
      s_axi_rvalid && s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad decerr");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid stuck");
  property p_walk_hold;
    walk_req_valid && !walk_rsp_valid |=> walk_req_valid;
  endproperty
  a_walk_hold: assert property (p_walk_hold) else $error("walk dropped");
  property p_walk_nobus;
    walk_req_valid |-> !bus_req_valid;
  endproperty
  a_walk_nobus: assert property (p_walk_nobus) else $error("walk on bus");
  property p_bus_hold;
    bus_req_valid && !bus_ack |=> bus_req_valid && $stable(bus_req_addr);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus req dropped");
  property p_refuse;
    walk_req_valid && walk_rsp_valid &&
      !(walk_rsp_pte[PTE_P] && walk_rsp_pte[PTE_A]) |->
      ##[1:4] (core_rsp_valid && core_rsp_fault);
  endproperty
  a_refuse: assert property (p_refuse) else $error("entry installed");
  property p_rsp_pulse;
    core_rsp_valid |=> !core_rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("rsp too long");
endmodule
bind ccl_core ccl_core_chk u_chk (.*);

//--- testbench/ccl_core_tb.sv
`timescale 1ns/1ps
module ccl_core_tb
  import ccl_pkg::*;
;
  localparam logic [31:0] A = 32'h0001_2040;
  localparam logic [31:0] B = 32'h0001_2080;
  logic clk_sys = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic core_req_valid = 0, core_req_write = 0, core_req_pfld = 0;
  logic core_req_super = 1, fetch_fault_valid = 0, walk_wr_valid = 0;
  logic ic_fill_valid = 0, f;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [6:0] pte_attr = 7'h0;
  logic [1:0] r;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, core_req_addr = 0, core_req_wdata = 0, d;
  logic [31:0] fetch_fault_vaddr = A, walk_wr_addr = A;
  logic [31:0] ic_fill_addr = A, ic_lookup_addr = A;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, irq, core_req_ready, core_rsp_valid, core_rsp_fault;
  wire walk_req_valid, walk_rsp_valid, bus_req_valid, bus_req_write;
  wire bus_ack, bus_shared, pfld_out_valid, ic_hit;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [19:0] walk_req_vpn, walk_req_root;
  wire [31:0] s_axi_rdata, core_rsp_data, walk_rsp_pte, bus_req_addr;
  wire [31:0] bus_req_wdata, bus_rdata, pfld_out_data;
  int err_total = 0, cmp_count = 0, nbus = 0, nwalk = 0;
  ccl_core DUT (.*);
  ccl_mem_model u_mem (.*);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (bus_req_valid && bus_ack) nbus++;
    if (walk_rsp_valid) nwalk++;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // a hung handshake ends the run here
  task automatic tmo(input int n);
    if (n >= 40) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic core(input logic [31:0] a, input logic w,
                      input logic [31:0] wd, input logic pf);
    int n;
    n = 0;
    @(posedge clk_sys);
    core_req_addr <= a;
    core_req_write <= w;
    core_req_wdata <= wd;
    core_req_pfld <= pf;
    core_req_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (core_req_ready) core_req_valid <= 1'b0;
      n++;
    end while (!core_rsp_valid && n < 40);
    d = core_rsp_data;
    f = core_rsp_fault;
    tmo(n);
  endtask
  task automatic pf_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!pfld_out_valid && n < 40);
    d = pfld_out_data;
    tmo(n);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    axi_rd(MASK_OFS);
    check(d, 32'h0);
    axi_rd(8'h40);
    check(d, 32'h0);
    check(r, RESP_DECERR);
    axi_wr(MASK_OFS, 32'h1f);
    pte_attr <= 7'h01;
    core(A, 0, 0, 0);
    check(f, 1);
    axi_rd(STAT_OFS);
    check(d[EV_REFUSE], 1);
    check(irq, 1);
    axi_wr(STAT_OFS, 32'h1f);
    axi_rd(STAT_OFS);
    check(d, 32'h0);
    check(irq, 0);
    $display("test regs and refusal done");
    pte_attr <= 7'h67;
    core(A, 0, 0, 0);
    check(d, 32'h2040c3c3);
    check(nwalk, 2);
    check(nbus, 1);
    core(A, 0, 0, 0);
    check(d, 32'h2040c3c3);
    check(nbus, 1);
    @(posedge clk_sys);
    walk_wr_valid <= 1'b1;
    @(posedge clk_sys);
    walk_wr_valid <= 1'b0;
    core(A, 0, 0, 0);
    check(nbus, 2);
    $display("test walk and snoop done");
    core(A, 1, 32'h1111_2222, 0);
    check(nbus, 2);
    pte_attr <= 7'h6f;
    axi_wr(ROOT_OFS, 32'h20);
    core(A, 1, 32'h3333_4444, 0);
    check(nbus, 2);
    check(nwalk, 3);
    core(A, 0, 0, 1);
    pf_wait();
    check(d, 32'h3333_4444);
    check(nbus, 2);
    core(B, 0, 0, 1);
    pf_wait();
    check(d, 32'h2080c3c3);
    core(B, 0, 0, 0);
    check(nbus, 5);
    $display("test store-through and float load done");
    @(posedge clk_sys);
    ic_fill_valid <= 1'b1;
    @(posedge clk_sys);
    ic_fill_valid <= 1'b0;
    @(posedge clk_sys);
    check(ic_hit, 1);
    pte_attr <= 7'h77;
    axi_wr(ROOT_OFS, 32'h20);
    axi_wr(CTRL_OFS, 32'h6);
    axi_rd(CTRL_OFS);
    check(d, 32'h6);
    core(B, 0, 0, 0);
    check(ic_hit, 0);
    check(nwalk, 4);
    check(d, 32'h2080c3c3);
    check(nbus, 5);
    axi_rd(STAT_OFS);
    check(d[EV_FLUSH], 1);
    $display("test flush and no-cache hit done");
    @(posedge clk_sys);
    fetch_fault_valid <= 1'b1;
    pte_attr <= 7'h37;
    @(posedge clk_sys);
    fetch_fault_valid <= 1'b0;
    core(A, 0, 0, 0);
    check(nwalk, 5);
    core(A, 1, 0, 0);
    check(f, 1);
    pte_attr <= 7'h77;
    core(A, 1, 0, 0);
    check(f, 0);
    check(nwalk, 6);
    $display("test fault invalidate done");
    final_report();
  end
endmodule
